// ==== verilog/bsd_unit.sv ====
// Purpose: packed decimal subtract, multiply and divide datapath
// Assumes: sequencer loads operand words, then writes the control word
// Notes: no wait states; operations run to completion while busy is high
//
// Chosen here: strobed register access and the address map.
`include "bsd_cfg.svh"

module bsd_unit
  import bsd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic busy,
  output logic done,
  output logic carry_flag,
  output logic zero_flag,
  output logic error_flag
);

  logic [15:0] opw [0:3];
  logic [15:0] res [0:3];
  logic [3:0] word_ok;
  bsd_op_t op;
  bsd_state_t state;

  logic [`BSD_NUM_W-1:0] dv_quo;
  logic [`BSD_NUM_W-1:0] dv_rem;
  logic [`BSD_NUM_W-1:0] dv_div;
  logic [4:0] dv_cnt;

  logic cv_start;
  logic [`BSD_VAL_W-1:0] cv_in;
  logic [`BSD_BCD_W-1:0] cv_bcd;
  logic cv_done;

  logic start_req;
  bsd_op_t new_op;
  logic new_dbl;
  logic new_legal;
  logic new_sub;
  logic new_mul;
  logic new_div;
  logic exec_on;
  logic fault_in;
  logic digits_ok;
  logic div_zero;
  logic bad;
  logic op_go;
  logic err_go;
  logic [`BSD_NUM_W-1:0] bin_a;
  logic [`BSD_NUM_W-1:0] bin_b;
  logic [`BSD_NUM_W:0] diff;
  logic sub_neg;
  logic [`BSD_NUM_W-1:0] sub_res;
  logic [`BSD_VAL_W-1:0] prod;
  logic mul_carry;
  logic [`BSD_NUM_W:0] dv_trial;
  logic dv_fits;

  // packed decimal to binary, most significant digit first
  function automatic logic [`BSD_NUM_W-1:0] bcd_to_bin(input logic [31:0] bcd);
    logic [`BSD_NUM_W-1:0] acc;
    acc = '0;
    for (int i = 7; i >= 0; i--)
    begin
      acc = `BSD_NUM_W'(acc * `BSD_NUM_W'(10)) + {23'h000000, bcd[4*i +: 4]};
    end
    return acc;
  endfunction : bcd_to_bin

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chk
      bsd_digit_check #(
        .DIGITS(4)
      ) u_chk (
        .word(opw[g]),
        .ok(word_ok[g])
      );
    end
  endgenerate

  bsd_bin2bcd u_conv (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(cv_start),
    .bin(cv_in),
    .bcd(cv_bcd),
    .done(cv_done)
  );

  // decode of the control word write that launches an operation
  always_comb
  begin
    start_req = ce && reg_wr && (reg_addr == `BSD_ADDR_CTRL)
      && reg_wdata[`BSD_CTRL_START] && (state == BSD_ST_IDLE);
    new_op = bsd_op_t'(reg_wdata[`BSD_CTRL_OP_MSB:`BSD_CTRL_OP_LSB]);
    new_legal = (reg_wdata[`BSD_CTRL_OP_MSB:`BSD_CTRL_OP_LSB] <= `BSD_LAST_OP);
    new_dbl = (new_op == BSD_OP_SUB_D) || (new_op == BSD_OP_MUL_D)
      || (new_op == BSD_OP_DIV_D);
    new_sub = (new_op == BSD_OP_SUB_S) || (new_op == BSD_OP_SUB_D);
    new_mul = (new_op == BSD_OP_MUL_S) || (new_op == BSD_OP_MUL_D);
    new_div = (new_op == BSD_OP_DIV_S) || (new_op == BSD_OP_DIV_D);
    exec_on = reg_wdata[`BSD_CTRL_EXEC];
    fault_in = reg_wdata[`BSD_CTRL_FAULT];
  end

  // operands: low word first for double length
  always_comb
  begin
    if (new_dbl)
    begin
      bin_a = bcd_to_bin({opw[1], opw[0]});
      bin_b = bcd_to_bin({opw[3], opw[2]});
    end
    else
    begin
      bin_a = bcd_to_bin({16'h0000, opw[0]});
      bin_b = bcd_to_bin({16'h0000, opw[2]});
    end
  end

  // validity: both single words, plus the high words for double forms
  always_comb
  begin
    digits_ok = word_ok[0] && word_ok[2];
    if (new_dbl)
    begin
      digits_ok = digits_ok && word_ok[1] && word_ok[3];
    end
    div_zero = new_div && (bin_b == '0);
    bad = !new_legal || !digits_ok || fault_in || div_zero;
    op_go = start_req && exec_on && !bad;
    err_go = start_req && exec_on && bad;
  end

  // subtract with borrow; a negative outcome wraps to the ten's complement
  always_comb
  begin
    diff = {1'b0, bin_a} - {1'b0, bin_b} - {`BSD_NUM_W'(0), carry_flag};
    sub_neg = diff[`BSD_NUM_W];
    if (!sub_neg)
    begin
      sub_res = diff[`BSD_NUM_W-1:0];
    end
    else if (new_dbl)
    begin
      sub_res = diff[`BSD_NUM_W-1:0] + `BSD_MOD8;
    end
    else
    begin
      sub_res = diff[`BSD_NUM_W-1:0] + `BSD_MOD4;
    end
  end

  // products fit the result words by construction, so carry stays low
  always_comb
  begin
    prod = {`BSD_NUM_W'(0), bin_a} * {`BSD_NUM_W'(0), bin_b};
    if (new_dbl)
    begin
      mul_carry = (prod >= `BSD_LIM16);
    end
    else
    begin
      mul_carry = (prod >= `BSD_LIM8);
    end
  end

  // one restoring step per cycle
  always_comb
  begin
    dv_trial = {dv_rem, dv_quo[`BSD_NUM_W-1]};
    dv_fits = (dv_trial >= {1'b0, dv_div});
  end

  // operand words: a whole word per write, so constants stay four digits
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        opw[i] <= `BSD_WORD_RST;
      end
    end
    else if (ce && reg_wr)
    begin
      unique case (reg_addr)
        `BSD_ADDR_OPA0: opw[0] <= reg_wdata;
        `BSD_ADDR_OPA1: opw[1] <= reg_wdata;
        `BSD_ADDR_OPB0: opw[2] <= reg_wdata;
        `BSD_ADDR_OPB1: opw[3] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // sequencing of an operation
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= BSD_ST_IDLE;
      op <= bsd_op_t'(`BSD_OP_RST);
      busy <= 1'b0;
      done <= 1'b0;
      cv_start <= 1'b0;
      cv_in <= '0;
      dv_quo <= '0;
      dv_rem <= '0;
      dv_div <= '0;
      dv_cnt <= 5'h00;
    end
    else if (ce)
    begin
      cv_start <= 1'b0;
      done <= 1'b0;
      unique case (state)
        BSD_ST_IDLE:
        begin
          if (start_req && !op_go)
          begin
            done <= 1'b1;
          end
          else if (op_go)
          begin
            op <= new_op;
            busy <= 1'b1;
            if (new_sub)
            begin
              cv_in <= {`BSD_NUM_W'(0), sub_res};
              cv_start <= 1'b1;
              state <= BSD_ST_CONV_A;
            end
            else if (new_mul)
            begin
              cv_in <= prod;
              cv_start <= 1'b1;
              state <= BSD_ST_CONV_A;
            end
            else
            begin
              dv_quo <= bin_a;
              dv_rem <= '0;
              dv_div <= bin_b;
              dv_cnt <= `BSD_DIV_STEPS;
              state <= BSD_ST_DIVIDE;
            end
          end
        end
        BSD_ST_DIVIDE:
        begin
          if (dv_cnt == 5'h00)
          begin
            cv_in <= {`BSD_NUM_W'(0), dv_quo};
            cv_start <= 1'b1;
            state <= BSD_ST_CONV_A;
          end
          else
          begin
            dv_cnt <= dv_cnt - 5'h01;
            if (dv_fits)
            begin
              dv_rem <= dv_trial[`BSD_NUM_W-1:0] - dv_div;
              dv_quo <= {dv_quo[`BSD_NUM_W-2:0], 1'b1};
            end
            else
            begin
              dv_rem <= dv_trial[`BSD_NUM_W-1:0];
              dv_quo <= {dv_quo[`BSD_NUM_W-2:0], 1'b0};
            end
          end
        end
        BSD_ST_CONV_A:
        begin
          if (cv_done)
          begin
            if ((op == BSD_OP_DIV_S) || (op == BSD_OP_DIV_D))
            begin
              cv_in <= {`BSD_NUM_W'(0), dv_rem};
              cv_start <= 1'b1;
              state <= BSD_ST_CONV_B;
            end
            else
            begin
              busy <= 1'b0;
              done <= 1'b1;
              state <= BSD_ST_IDLE;
            end
          end
        end
        BSD_ST_CONV_B:
        begin
          if (cv_done)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= BSD_ST_IDLE;
          end
        end
      endcase
    end
  end

  // result words; an operation that is off or in error leaves them alone
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        res[i] <= `BSD_WORD_RST;
      end
    end
    else if (ce && cv_done && (state == BSD_ST_CONV_A))
    begin
      unique case (op)
        BSD_OP_SUB_S, BSD_OP_DIV_S:
        begin
          res[0] <= cv_bcd[15:0];
        end
        BSD_OP_SUB_D, BSD_OP_MUL_S, BSD_OP_DIV_D:
        begin
          res[0] <= cv_bcd[15:0];
          res[1] <= cv_bcd[31:16];
        end
        BSD_OP_MUL_D:
        begin
          res[0] <= cv_bcd[15:0];
          res[1] <= cv_bcd[31:16];
          res[2] <= cv_bcd[47:32];
          res[3] <= cv_bcd[63:48];
        end
        default: ;
      endcase
    end
    else if (ce && cv_done && (state == BSD_ST_CONV_B))
    begin
      if (op == BSD_OP_DIV_S)
      begin
        res[1] <= cv_bcd[15:0];
      end
      else
      begin
        res[2] <= cv_bcd[15:0];
        res[3] <= cv_bcd[31:16];
      end
    end
  end

  // flags; the unit's own carry update wins over a software write
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      error_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (err_go)
      begin
        error_flag <= 1'b1;
      end
      else if (op_go)
      begin
        error_flag <= 1'b0;
      end
      if (op_go && new_sub)
      begin
        carry_flag <= sub_neg;
      end
      else if (op_go && new_mul)
      begin
        carry_flag <= mul_carry;
      end
      else if (reg_wr && (reg_addr == `BSD_ADDR_FLAGS))
      begin
        carry_flag <= reg_wdata[`BSD_FLAG_CARRY];
      end
      if (cv_done && (state == BSD_ST_CONV_A))
      begin
        zero_flag <= (cv_bcd == '0);
      end
    end
  end

  // read data stand one cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      reg_rdata <= `BSD_WORD_RST;
    end
    else if (ce)
    begin
      reg_rdata <= `BSD_WORD_RST;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `BSD_ADDR_CTRL:
          begin
            reg_rdata[`BSD_CTRL_OP_MSB:`BSD_CTRL_OP_LSB] <= op;
            reg_rdata[`BSD_CTRL_BUSY] <= busy;
          end
          `BSD_ADDR_OPA0: reg_rdata <= opw[0];
          `BSD_ADDR_OPA1: reg_rdata <= opw[1];
          `BSD_ADDR_OPB0: reg_rdata <= opw[2];
          `BSD_ADDR_OPB1: reg_rdata <= opw[3];
          `BSD_ADDR_RES0: reg_rdata <= res[0];
          `BSD_ADDR_RES1: reg_rdata <= res[1];
          `BSD_ADDR_RES2: reg_rdata <= res[2];
          `BSD_ADDR_RES3: reg_rdata <= res[3];
          `BSD_ADDR_FLAGS:
          begin
            reg_rdata[`BSD_FLAG_CARRY] <= carry_flag;
            reg_rdata[`BSD_FLAG_ZERO] <= zero_flag;
            reg_rdata[`BSD_FLAG_ERROR] <= error_flag;
          end
          default: ;
        endcase
      end
    end
  end

endmodule : bsd_unit

// ==== verilog/bsd_cfg.svh ====
// Purpose: named constants of the decimal arithmetic unit
// Assumes: 16-bit packed decimal words, 4-bit register index
// Notes: definitions only
`ifndef BSD_CFG_SVH
`define BSD_CFG_SVH

// register index on the plain register port
`define BSD_ADDR_CTRL 4'h0
`define BSD_ADDR_OPA0 4'h1
`define BSD_ADDR_OPA1 4'h2
`define BSD_ADDR_OPB0 4'h3
`define BSD_ADDR_OPB1 4'h4
`define BSD_ADDR_RES0 4'h5
`define BSD_ADDR_RES1 4'h6
`define BSD_ADDR_RES2 4'h7
`define BSD_ADDR_RES3 4'h8
`define BSD_ADDR_FLAGS 4'h9

// control word fields
`define BSD_CTRL_OP_MSB 2
`define BSD_CTRL_OP_LSB 0
`define BSD_CTRL_EXEC 3
`define BSD_CTRL_FAULT 4
`define BSD_CTRL_START 8
`define BSD_CTRL_BUSY 15

// flag word fields
`define BSD_FLAG_CARRY 0
`define BSD_FLAG_ZERO 1
`define BSD_FLAG_ERROR 2

// reset values and the highest legal operation code
`define BSD_WORD_RST 16'h0000
`define BSD_OP_RST 3'h0
`define BSD_LAST_OP 3'h5

// arithmetic sizes and limits
`define BSD_NUM_W 27
`define BSD_VAL_W 54
`define BSD_BCD_W 64
`define BSD_DIGIT_MAX 4'h9
`define BSD_MOD4 27'h0002710
`define BSD_MOD8 27'h5F5E100
`define BSD_LIM8 54'h000000005F5E100
`define BSD_LIM16 54'h2386F26FC10000
`define BSD_DIV_STEPS 5'h1B
`define BSD_CONV_STEPS 6'h36

`endif

// ==== verilog/bsd_pkg.sv ====
// Purpose: types of the decimal arithmetic unit
// Assumes: nothing beyond the constants header
// Notes: operation codes as software writes them into the control word
package bsd_pkg;

  typedef enum logic [2:0] {
    BSD_OP_SUB_S = 3'b000,
    BSD_OP_SUB_D = 3'b001,
    BSD_OP_MUL_S = 3'b010,
    BSD_OP_MUL_D = 3'b011,
    BSD_OP_DIV_S = 3'b100,
    BSD_OP_DIV_D = 3'b101,
    BSD_OP_RSV6 = 3'b110,
    BSD_OP_RSV7 = 3'b111
  } bsd_op_t;

  typedef enum logic [1:0] {
    BSD_ST_IDLE = 2'b00,
    BSD_ST_DIVIDE = 2'b01,
    BSD_ST_CONV_A = 2'b10,
    BSD_ST_CONV_B = 2'b11
  } bsd_state_t;

endpackage : bsd_pkg

// ==== verilog/bsd_digit_check.sv ====
// Purpose: flags a packed word whose nibbles are all decimal digits
// Assumes: purely combinational, same clock domain as the reader
// Notes: one instance per operand word
`include "bsd_cfg.svh"

module bsd_digit_check
  import bsd_pkg::*;
#(
  parameter int DIGITS = 4
)
(
  input wire logic [4*DIGITS-1:0] word,
  output logic ok
);

  always_comb
  begin
    ok = 1'b1;
    for (int i = 0; i < DIGITS; i++)
    begin
      if (word[4*i +: 4] > `BSD_DIGIT_MAX)
      begin
        ok = 1'b0;
      end
    end
  end

endmodule : bsd_digit_check

// ==== verilog/bsd_bin2bcd.sv ====
// Purpose: sequential binary to packed decimal conversion
// Assumes: start is a one-cycle pulse, input held only in that cycle
// Notes: shift-and-add-three, one bit per enabled cycle
`include "bsd_cfg.svh"

module bsd_bin2bcd
  import bsd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [`BSD_VAL_W-1:0] bin,
  output logic [`BSD_BCD_W-1:0] bcd,
  output logic done
);

  logic [`BSD_VAL_W-1:0] shift_q;
  logic [5:0] cnt;
  logic active;
  logic [`BSD_BCD_W-1:0] adj;

  // digits of 5 or more get 3 added so the shift carries into the next digit
  always_comb
  begin
    adj = bcd;
    for (int i = 0; i < `BSD_BCD_W / 4; i++)
    begin
      if (bcd[4*i +: 4] > 4'h4)
      begin
        adj[4*i +: 4] = bcd[4*i +: 4] + 4'h3;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      shift_q <= '0;
      bcd <= '0;
      cnt <= 6'h00;
      active <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start)
      begin
        shift_q <= bin;
        bcd <= '0;
        cnt <= `BSD_CONV_STEPS;
        active <= 1'b1;
      end
      else if (active)
      begin
        bcd <= {adj[`BSD_BCD_W-2:0], shift_q[`BSD_VAL_W-1]};
        shift_q <= {shift_q[`BSD_VAL_W-2:0], 1'b0};
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01)
        begin
          active <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : bsd_bin2bcd

// ==== bench/bsd_unit_checker.sv ====
// Purpose: port-level checks of the decimal arithmetic unit
// Assumes: one clock domain, synchronous active-high reset
// Notes: run lengths are counted in clock-enabled cycles
module bsd_unit_checker
  import bsd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic busy,
  input wire logic done,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic error_flag
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  logic take;
  logic quick;
  logic [2:0] op_q;
  logic ex_q;
  logic [7:0] cnt;

  assign take = ce && reg_wr && reg_addr == 4'h0 && reg_wdata[8] && !busy;
  // starts that never reach the datapath
  assign quick = !reg_wdata[3] || reg_wdata[4] || reg_wdata[2:1] == 2'b11;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      op_q <= 3'h0;
      ex_q <= 1'b0;
    end
    else if (take)
    begin
      op_q <= reg_wdata[2:0];
      ex_q <= reg_wdata[3];
    end
  end

  // stops at zero after a wrap, so a long idle spell is harmless
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt <= 8'h00;
    else if (take)
      cnt <= 8'h01;
    else if (ce && cnt != 8'h00)
      cnt <= cnt + 8'h01;
  end

  AST_RD_IDLE: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  AST_COND_OFF: assert property (take && !reg_wdata[3] |=>
    ($stable(carry_flag) && $stable(zero_flag) && $stable(error_flag)) [*2])
    else $error("flags moved with the condition off");
  AST_QUICK_DONE: assert property (take && quick |-> ##[1:2] done)
    else $error("refused start gave no prompt done");
  AST_FAULT: assert property (take && reg_wdata[3] && reg_wdata[4] |-> ##[1:2] error_flag)
    else $error("operand fault did not raise error");
  AST_ERR_KEEP: assert property ($rose(error_flag) |->
    done && $stable(carry_flag) && $stable(zero_flag))
    else $error("error raised without done or with flag change");
  // divide: 27 steps, then two conversions back to back
  AST_RUN_TIME: assert property (done && ex_q && !error_flag |->
    (op_q[2] ? (cnt == 8'h8C || cnt == 8'h8D) : (cnt == 8'h38 || cnt == 8'h39)))
    else $error("operation length off");
  // a frozen cycle holds done, so only an enabled edge clears it
  AST_DONE_PULSE: assert property (done && ce |=> !done)
    else $error("done longer than one cycle");
  AST_BUSY_END: assert property (done |-> !busy)
    else $error("busy still high with done");
  AST_CARRY_WR: assert property (ce && reg_wr && reg_addr == 4'h9 && !busy |=>
    carry_flag == $past(reg_wdata[0]))
    else $error("carry write not taken");
endmodule : bsd_unit_checker

// ==== bench/bsd_seq_model.sv ====
// Purpose: sequencer model driving the plain register port
// Assumes: strobes launched just after a rising edge, one cycle long
// Notes: released address and data show the inverse of the last value
module bsd_seq_model
  import bsd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata,
  input wire logic done,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic clear_carry();
    wr(4'h9, 16'h0000);
  endtask : clear_carry

  task automatic wait_done(input int lim, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < lim && ok !== 1'b1; n++)
    begin
      @(negedge clk_sys);
      ok = done;
    end
  endtask : wait_done
endmodule : bsd_seq_model

// ==== bench/tb_bsd_unit.sv ====
// Purpose: self-checking bench of the decimal arithmetic unit
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes: expectations come from integer arithmetic on the operands
module tb_bsd_unit
  import bsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys;
  logic sys_rst;
  logic ce;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic busy;
  logic done;
  logic carry_flag;
  logic zero_flag;
  logic error_flag;
  int n_fail = 0;
  int checked = 0;

  bsd_unit bsd_unit_i (.clk_sys, .sys_rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .busy, .done, .carry_flag, .zero_flag, .error_flag);
  bsd_seq_model bsd_seq_model_i (.clk_sys, .reg_rdata, .done, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd);

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checked %0d, failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  initial
  begin
    #(40 * 12000);
    n_fail++;
    close_out();
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [63:0] d2b(input longint v);
    logic [63:0] r;
    r = 64'h0;
    for (int k = 0; k < 16; k++)
    begin
      r[4*k+:4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction : d2b

  task automatic rres(output logic [63:0] r, output logic [15:0] f);
    for (int k = 0; k < 4; k++)
      bsd_seq_model_i.rd(4'(5 + k), r[16*k+:16]);
    bsd_seq_model_i.rd(4'h9, f);
    f = f & 16'h0007;
  endtask : rres

  task automatic run(input logic [2:0] op, input logic ex, input logic flt,
    input logic [63:0] a, input logic [63:0] b, input logic c, input int lim);
    logic ok;
    bsd_seq_model_i.clear_carry();
    if (c)
      bsd_seq_model_i.wr(4'h9, 16'h0001);
    bsd_seq_model_i.wr(4'h1, a[15:0]);
    bsd_seq_model_i.wr(4'h2, a[31:16]);
    bsd_seq_model_i.wr(4'h3, b[15:0]);
    bsd_seq_model_i.wr(4'h4, b[31:16]);
    bsd_seq_model_i.wr(4'h0, {7'h00, 1'b1, 3'h0, flt, ex, op});
    bsd_seq_model_i.wait_done(lim, ok);
    chk("done", {15'h0000, ok}, 16'h0001);
  endtask : run

  task automatic op_ok(input logic [2:0] op, input longint a, input longint b, input logic c);
    longint m;
    longint r;
    longint q;
    logic [63:0] e;
    logic [63:0] t;
    logic [63:0] got;
    logic [15:0] f;
    logic [15:0] cw;
    logic ecy;
    int nw;
    m = op[0] ? 100000000 : 10000;
    ecy = c;
    nw = op[0] ? 4 : 2;
    if (op[2:1] == 2'b00)
    begin
      r = (m + a - b - c) % m;
      ecy = a < b + c;
      q = r;
      nw = op[0] ? 2 : 1;
    end
    else if (op[2:1] == 2'b01)
    begin
      r = a * b;
      ecy = 1'b0;
      q = r;
    end
    else
    begin
      q = a / b;
      r = a % b;
    end
    e = d2b(q);
    t = d2b(r);
    if (op[2] && op[0])
      e[63:32] = t[31:0];
    else if (op[2])
      e[31:16] = t[15:0];
    // divide finishes 140 enabled cycles after the start
    run(op, 1'b1, 1'b0, d2b(a), d2b(b), c, 200);
    rres(got, f);
    for (int k = 0; k < nw; k++)
      chk("result", got[16*k+:16], e[16*k+:16]);
    chk("flags", f, {13'h0000, 1'b0, q == 0, ecy});
    bsd_seq_model_i.rd(4'h0, cw);
    chk("ctrl", cw, {13'h0000, op});
    $display("test op %0d done", op);
  endtask : op_ok

  // refused or skipped starts must leave every result, carry and zero alone; refused ones raise error
  task automatic err_case(input logic [2:0] op, input logic ex, input logic flt,
    input logic [63:0] a, input logic [63:0] b);
    logic [63:0] r0;
    logic [63:0] r1;
    logic [15:0] f0;
    logic [15:0] f1;
    rres(r0, f0);
    run(op, ex, flt, a, b, f0[0], 4);
    rres(r1, f1);
    for (int k = 0; k < 4; k++)
      chk("kept", r1[16*k+:16], r0[16*k+:16]);
    chk("flags", f1, {13'h0000, ex | f0[2], f0[1:0]});
    $display("test refused op %0d done", op);
  endtask : err_case

  initial
  begin
    logic [15:0] v;
    ce = 1'b1;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int k = 0; k < 11; k++)
    begin
      bsd_seq_model_i.rd(4'(k), v);
      chk("reset", v, 16'h0000);
    end
    bsd_seq_model_i.wr(4'h5, 16'h1234);
    bsd_seq_model_i.rd(4'h5, v);
    chk("readonly", v, 16'h0000);
    $display("test reset and read-only done");
    op_ok(BSD_OP_SUB_S, 1029, 3452, 1'b0);
    op_ok(BSD_OP_SUB_S, 0, 7577, 1'b0);
    op_ok(BSD_OP_SUB_S, 5000, 4999, 1'b1);
    op_ok(BSD_OP_SUB_S, 4999, 4999, 1'b1);
    op_ok(BSD_OP_SUB_D, 12345678, 87654321, 1'b0);
    op_ok(BSD_OP_SUB_D, 10000, 1, 1'b1);
    // freeze mid-run: the count must stretch, not restart
    fork
      op_ok(BSD_OP_MUL_S, 9999, 9999, 1'b0);
      begin
        repeat (40) @(posedge clk_sys);
        ce <= 1'b0;
        repeat (10) @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    op_ok(BSD_OP_MUL_S, 0, 1234, 1'b1);
    op_ok(BSD_OP_MUL_D, 99999999, 99999999, 1'b0);
    op_ok(BSD_OP_DIV_S, 9999, 7, 1'b1);
    op_ok(BSD_OP_DIV_S, 5, 9, 1'b0);
    op_ok(BSD_OP_DIV_D, 87654321, 1234, 1'b0);
    op_ok(BSD_OP_DIV_D, 99999999, 99999999, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      err_case(3'(k), 1'b1, 1'b0, 64'h1234, k[0] ? 64'h00A00001 : 64'h000B);
      err_case(3'(k), 1'b1, 1'b0, k[0] ? 64'hC0000001 : 64'hF000, 64'h5);
    end
    err_case(BSD_OP_DIV_D, 1'b1, 1'b0, 64'h1234, 64'h0);
    err_case(BSD_OP_DIV_S, 1'b1, 1'b0, 64'h1234, 64'h0);
    err_case(BSD_OP_SUB_S, 1'b1, 1'b1, 64'h5, 64'h1);
    err_case(BSD_OP_RSV6, 1'b1, 1'b0, 64'h5, 64'h1);
    err_case(BSD_OP_RSV7, 1'b1, 1'b0, 64'h5, 64'h1);
    err_case(BSD_OP_SUB_D, 1'b0, 1'b0, 64'h12, 64'h34);
    op_ok(BSD_OP_MUL_D, 12345678, 0, 1'b0);
    err_case(BSD_OP_MUL_S, 1'b0, 1'b0, 64'h12, 64'h34);
    err_case(BSD_OP_DIV_D, 1'b0, 1'b0, 64'h12, 64'h34);
    close_out();
  end
endmodule : tb_bsd_unit

bind bsd_unit bsd_unit_checker bsd_unit_checker_i (.clk_sys, .sys_rst, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .busy, .done, .carry_flag, .zero_flag,
  .error_flag);
